//--- hw/rst_mode_defines.svh
`ifndef RST_MODE_DEFINES_SVH
`define RST_MODE_DEFINES_SVH
`define RESET_HOLD_CYCLES  7'h42
`define BIT_TIME_CYCLES    5'h10
`define SPEEDUP_CYCLES     2'h1
`define CAUSE_POR_BIT      7
`define CAUSE_PIN_BIT      6
`define CAUSE_WDOG_BIT     5
`define CAUSE_ILOP_BIT     4
`define CAUSE_ILAD_BIT     3
`define CAUSE_DBG_BIT      2
`define CAUSE_LVD_BIT      1
`define CAUSE_RESET_VALUE  8'h00
`define CAUSE_POR_VALUE    8'h80
`define GPIO_WIDTH         22
`endif

//--- hw/rst_mode_pkg.sv
package rst_mode_pkg;
	typedef struct packed {
		logic por;
		logic pin;
		logic wdog;
		logic illegal_op;
		logic illegal_addr;
		logic debug_force;
		logic low_voltage;
	} reset_sources_t;
	typedef struct packed {
		logic in;
		logic out;
		logic oe;
	} pin3_t;
	typedef enum logic [1:0] {
		ST_RUN,
		ST_HOLD,
		ST_RELEASE
	} rst_state_t;
endpackage : rst_mode_pkg

//--- hw/bus_clock_divider.sv
`timescale 1ns/1ps
// Bus clock enable: every second edge of the generator clock
module bus_clock_divider (
	input  wire logic mclk_in,    // Clock generator output
	input  wire logic reset_in,   // Async reset, active high
	output logic      bus_en_out  // One-cycle bus clock enable
);
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			bus_en_out <= 1'b0;
		end else begin
			bus_en_out <= ~bus_en_out;
		end
	end
	a_div_alternate: assert property (@(posedge mclk_in) disable iff (reset_in)
		bus_en_out |=> !bus_en_out) else $error("bus enable not halved");
endmodule : bus_clock_divider

//--- hw/reset_and_debug_mode_select.sv
`timescale 1ns/1ps
`include "rst_mode_defines.svh"
module reset_and_debug_mode_select
	import rst_mode_pkg::*;
(
	input  wire logic                    mclk_in,             // Clock generator output, 25 MHz
	input  wire logic                    reset_in,            // Async reset, active high
	input  wire reset_sources_t          sources_in,          // Reset source requests
	input  wire logic                    background_pin_in,   // Shared pin level
	input  wire logic                    dbg_tx_valid_in,     // Debug controller sends a bit
	input  wire logic                    dbg_tx_bit_in,       // Bit value to send
	output logic                         reset_pin_n_out,     // Active-low reset pin
	output logic                         internal_reset_out,  // Internal reset, high in reset
	output logic [7:0]                   reset_cause_register_out, // Reset cause status
	output logic                         background_mode_out, // 1 = active background mode
	output logic                         debug_link_en_out,   // Pin acts as debug line
	output logic                         background_pin_out,  // Pin drive level
	output logic                         background_pin_oe_out, // Pin drive enable
	output logic                         dbg_rx_bit_out,      // Sampled bit level
	output logic                         dbg_bit_done_out,    // Bit time done pulse
	output logic                         bus_en_out,          // Bus clock enable
	output logic [`GPIO_WIDTH-1:0]       gpio_oe_out,         // GPIO drive enables
	output logic [`GPIO_WIDTH-1:0]       gpio_pullup_out      // GPIO pull-up enables
);
	logic             bus_en;
	rst_state_t       state_reg;
	rst_state_t       state_next;
	logic [6:0]       hold_reg;
	logic [7:0]       cause_next;
	logic             mode_sample;
	logic             any_src;
	logic [4:0]       bit_cnt_reg;
	logic             tx_bit_reg;
	logic             tx_busy_reg;
	logic [7:0]       low_gap_reg;

	bus_clock_divider u_div (
		.mclk_in    (mclk_in),
		.reset_in   (reset_in),
		.bus_en_out (bus_en)
	);

	assign any_src = |sources_in;
	// Mode is chosen only by power-on or debug-forced resets
	assign mode_sample = sources_in.por | sources_in.debug_force;

	function automatic logic [7:0] decode_cause(input reset_sources_t s);
		logic [7:0] c;
		c = `CAUSE_RESET_VALUE;
		c[`CAUSE_POR_BIT]  = s.por;
		c[`CAUSE_PIN_BIT]  = s.pin & ~s.por;
		c[`CAUSE_WDOG_BIT] = s.wdog & ~s.por;
		c[`CAUSE_ILOP_BIT] = s.illegal_op & ~s.por;
		c[`CAUSE_ILAD_BIT] = s.illegal_addr & ~s.por;
		c[`CAUSE_DBG_BIT]  = s.debug_force & ~s.por;
		c[`CAUSE_LVD_BIT]  = s.low_voltage;
		return c;
	endfunction : decode_cause

	assign cause_next = decode_cause(sources_in);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN:     if (any_src) state_next = ST_HOLD;
			ST_HOLD:    if (bus_en && hold_reg == 7'h01 && !any_src) state_next = ST_RELEASE;
			// New source in the release cycle must not be lost
			ST_RELEASE: state_next = any_src ? ST_HOLD : ST_RUN;
			default:    state_next = ST_RUN;
		endcase
	end

	logic mode_pending_reg;
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg <= ST_HOLD;
			hold_reg <= `RESET_HOLD_CYCLES;
			reset_pin_n_out <= 1'b0;
			internal_reset_out <= 1'b1;
			reset_cause_register_out <= `CAUSE_POR_VALUE;
			mode_pending_reg <= 1'b1;
			background_mode_out <= 1'b0;
			debug_link_en_out <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (any_src) begin
				hold_reg <= `RESET_HOLD_CYCLES;
				reset_cause_register_out <= cause_next;
				if (mode_sample) mode_pending_reg <= 1'b1;
			end else if (bus_en && hold_reg != 7'h00) begin
				hold_reg <= hold_reg - 7'h01;
			end
			reset_pin_n_out <= (state_next == ST_RUN);
			internal_reset_out <= (state_next != ST_RUN);
			debug_link_en_out <= (state_next == ST_RUN);
			// Source in the release cycle restarts the hold; the mode is sampled later
			if (state_reg == ST_RELEASE && state_next == ST_RUN && mode_pending_reg) begin
				background_mode_out <= ~background_pin_in;
				mode_pending_reg <= 1'b0;
			end
		end
	end

	// Bit timing; speedup pulse drives high for one cycle at the end of every bit
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			bit_cnt_reg <= 5'h00;
			tx_bit_reg <= 1'b1;
			tx_busy_reg <= 1'b0;
			background_pin_out <= 1'b0;
			background_pin_oe_out <= 1'b0;
			dbg_rx_bit_out <= 1'b1;
			dbg_bit_done_out <= 1'b0;
		end else begin
			dbg_bit_done_out <= 1'b0;
			if (!debug_link_en_out) begin
				tx_busy_reg <= 1'b0;
				background_pin_oe_out <= 1'b0;
				bit_cnt_reg <= 5'h00;
			end else if (!tx_busy_reg) begin
				if (dbg_tx_valid_in) begin
					tx_busy_reg <= 1'b1;
					tx_bit_reg <= dbg_tx_bit_in;
					bit_cnt_reg <= `BIT_TIME_CYCLES - 5'h01;
					background_pin_out <= 1'b0;
					background_pin_oe_out <= 1'b1;
				end
			end else begin
				bit_cnt_reg <= bit_cnt_reg - 5'h01;
				if (bit_cnt_reg == 5'h0c) begin
					background_pin_out <= tx_bit_reg; // Speedup high for a one
					background_pin_oe_out <= 1'b1;
				end else if (bit_cnt_reg == 5'h0b) begin
					background_pin_oe_out <= ~tx_bit_reg;
				end else if (bit_cnt_reg == 5'h01) begin
					background_pin_out <= 1'b1; // Speedup before release
					background_pin_oe_out <= 1'b1;
				end else if (bit_cnt_reg == 5'h00) begin
					background_pin_oe_out <= 1'b0;
					tx_busy_reg <= 1'b0;
					dbg_bit_done_out <= 1'b1;
				end
				if (bit_cnt_reg == 5'h08) dbg_rx_bit_out <= background_pin_in;
			end
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			bus_en_out <= 1'b0;
			gpio_oe_out <= '0;
			gpio_pullup_out <= '0;
		end else begin
			bus_en_out <= bus_en;
			if (internal_reset_out) begin
				gpio_oe_out <= '0;
				gpio_pullup_out <= '0;
			end
		end
	end

	// Clocks since the last reset source, saturating; feeds only the hold-length check
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			low_gap_reg <= 8'h00;
		end else if (any_src) begin
			low_gap_reg <= 8'h00;
		end else if (low_gap_reg != 8'hff) begin
			low_gap_reg <= low_gap_reg + 8'h01;
		end
	end

	a_hold_low_pin: assert property (@(posedge mclk_in) disable iff (reset_in)
		$rose(any_src) |=> !reset_pin_n_out [*8]) else $error("reset pin released early");
	a_cause_set: assert property (@(posedge mclk_in) disable iff (reset_in)
		sources_in.por |=> reset_cause_register_out[`CAUSE_POR_BIT]) else $error("cause not recorded");
	a_pin_no_drive: assert property (@(posedge mclk_in) disable iff (reset_in)
		internal_reset_out |-> ##1 !background_pin_oe_out) else $error("pin driven in reset");
	a_link_after: assert property (@(posedge mclk_in) disable iff (reset_in)
		$fell(internal_reset_out) |-> debug_link_en_out) else $error("link not enabled");
	a_mode_normal: assert property (@(posedge mclk_in) disable iff (reset_in)
		(state_reg == ST_RELEASE && !any_src && mode_pending_reg && background_pin_in) |=> !background_mode_out)
		else $error("normal mode not chosen");
	a_bit_time: assert property (@(posedge mclk_in) disable iff (reset_in)
		(debug_link_en_out && !tx_busy_reg && dbg_tx_valid_in) |-> ##17 dbg_bit_done_out)
		else $error("bit time not 16 cycles");
	a_speedup_pulse: assert property (@(posedge mclk_in) disable iff (reset_in)
		(tx_busy_reg && bit_cnt_reg == 5'h01) |=> background_pin_oe_out && background_pin_out)
		else $error("no speedup pulse");
	a_gpio_inputs: assert property (@(posedge mclk_in) disable iff (reset_in)
		$fell(internal_reset_out) |-> gpio_oe_out == '0 && gpio_pullup_out == '0)
		else $error("gpio not input");
	a_mode_held: assert property (@(posedge mclk_in) disable iff (reset_in)
		(!mode_pending_reg && !mode_sample) |=> $stable(background_mode_out)) else $error("mode changed");

	// Hold is 66 bus cycles; the bus enable phase adds at most one clock
	a_hold_length: assert property (@(posedge mclk_in) disable iff (reset_in)
		$rose(reset_pin_n_out) |-> (low_gap_reg >= {`RESET_HOLD_CYCLES, 1'b0}
		&& low_gap_reg <= {`RESET_HOLD_CYCLES, 1'b0} + 8'h01)) else $error("reset hold length wrong");
	a_hold_restart: assert property (@(posedge mclk_in) disable iff (reset_in)
		any_src |=> !reset_pin_n_out && hold_reg == `RESET_HOLD_CYCLES) else $error("hold not restarted");
	a_release_once: assert property (@(posedge mclk_in) disable iff (reset_in)
		state_reg == ST_RELEASE |=> state_reg != ST_RELEASE) else $error("release state stuck");

	a_cause_debug: assert property (@(posedge mclk_in) disable iff (reset_in)
		(sources_in.debug_force && !sources_in.por) |=> reset_cause_register_out[`CAUSE_DBG_BIT])
		else $error("debug force cause missing");
	a_cause_masked: assert property (@(posedge mclk_in) disable iff (reset_in)
		sources_in.por |=> !reset_cause_register_out[`CAUSE_PIN_BIT]) else $error("pin cause not masked");

	a_mode_forced: assert property (@(posedge mclk_in) disable iff (reset_in)
		(state_reg == ST_RELEASE && !any_src && mode_pending_reg && !background_pin_in)
		|=> background_mode_out) else $error("background mode not chosen");
	a_link_idle: assert property (@(posedge mclk_in) disable iff (reset_in)
		!debug_link_en_out |=> !tx_busy_reg && !background_pin_oe_out) else $error("link active in reset");

	// Bit level is taken mid-bit, once the far end has settled the line
	a_rx_sample: assert property (@(posedge mclk_in) disable iff (reset_in)
		(debug_link_en_out && tx_busy_reg && bit_cnt_reg == 5'h08)
		|=> dbg_rx_bit_out == $past(background_pin_in)) else $error("bit level not sampled");
	a_bit_refused: assert property (@(posedge mclk_in) disable iff (reset_in)
		(debug_link_en_out && tx_busy_reg && bit_cnt_reg != 5'h00) |=> tx_busy_reg
		&& bit_cnt_reg == $past(bit_cnt_reg) - 5'h01) else $error("bit restarted while busy");
	a_speedup_one: assert property (@(posedge mclk_in) disable iff (reset_in)
		(debug_link_en_out && tx_busy_reg && bit_cnt_reg == 5'h0c && tx_bit_reg)
		|=> (background_pin_oe_out && background_pin_out) ##1 !background_pin_oe_out) else $error("one not sped up");

	a_bus_rate: assert property (@(posedge mclk_in) disable iff (reset_in)
		bus_en_out |=> !bus_en_out ##1 bus_en_out) else $error("bus enable not half rate");
endmodule : reset_and_debug_mode_select

//--- tb/debug_host_model.sv
`timescale 1ns/1ps
// Host end of the shared pin; the pull-up wins whenever nobody drives
module debug_host_model (
	input  wire logic hold_low_in, // Host pulls the pin low
	input  wire logic dev_out_in,  // Device drive level
	input  wire logic dev_oe_in,   // Device drive enable
	output logic      pin_out      // Resolved pin level
);
	assign pin_out = dev_oe_in ? dev_out_in : (hold_low_in ? 1'b0 : 1'b1);
endmodule : debug_host_model

//--- tb/reset_and_debug_mode_select_bench.sv
`timescale 1ns/1ps
module reset_and_debug_mode_select_bench;
	import rst_mode_pkg::*;
	logic           mclk_in, reset_in, hold_low, tx_valid, tx_bit, pin, rst_n, int_rst, mode;
	logic           link_en, pin_o, pin_oe, rx_bit, done, bus_en, exp_mode, hi, b;
	reset_sources_t src;
	logic [7:0]     cause;
	logic [21:0]    gpio_oe, gpio_pu;
	logic           exp_q[$];
	logic [31:0]    seed;
	int             num_errors, comparisons, n;
	reset_and_debug_mode_select dut (.mclk_in(mclk_in), .reset_in(reset_in), .sources_in(src),
		.background_pin_in(pin), .dbg_tx_valid_in(tx_valid), .dbg_tx_bit_in(tx_bit),
		.reset_pin_n_out(rst_n), .internal_reset_out(int_rst), .reset_cause_register_out(cause),
		.background_mode_out(mode), .debug_link_en_out(link_en), .background_pin_out(pin_o),
		.background_pin_oe_out(pin_oe), .dbg_rx_bit_out(rx_bit), .dbg_bit_done_out(done),
		.bus_en_out(bus_en), .gpio_oe_out(gpio_oe), .gpio_pullup_out(gpio_pu));
	debug_host_model host (.hold_low_in(hold_low), .dev_out_in(pin_o), .dev_oe_in(pin_oe), .pin_out(pin));
	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	task automatic chk(input logic ok, input string what);
		comparisons++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask : chk
	task automatic stop_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// Host keeps the pin low until the mode has been sampled
	task automatic settle(input logic [7:0] exp_cause);
		n = 1;
		while (rst_n !== 1'b1 && n < 300) begin
			@(negedge mclk_in);
			n++;
		end
		repeat (4) @(negedge mclk_in);
		hold_low = 1'b0;
		repeat (2) @(negedge mclk_in);
		chk(cause === exp_cause, "reset cause");
		chk(mode === exp_mode, "boot mode");
		chk(link_en === 1'b1 && int_rst === 1'b0, "debug line after reset");
		chk(gpio_oe === '0 && gpio_pu === '0, "gpio state");
	endtask : settle
	task automatic hit(input reset_sources_t s, input logic [7:0] exp_cause);
		@(negedge mclk_in) src = s;
		@(negedge mclk_in) src = '0;
		chk(rst_n === 1'b0 && int_rst === 1'b1, "reset pin not low");
		settle(exp_cause);
		chk(n >= 128 && n <= 140, "reset hold length");
	endtask : hit
	// Scoreboard: oldest expected bit against each completed bit
	always @(negedge mclk_in) begin
		if (done === 1'b1) begin
			if (exp_q.size() == 0)
				chk(1'b0, "unexpected bit");
			else
				chk(rx_bit === exp_q.pop_front(), "received bit");
		end
	end
	initial begin
		reset_in = 1'b1;
		src = '0;
		hold_low = 1'b0;
		tx_valid = 1'b0;
		tx_bit = 1'b0;
		seed = 32'h1608;
		exp_mode = 1'b0;
		num_errors = 0;
		comparisons = 0;
		repeat (12) @(negedge mclk_in);
		chk(rst_n === 1'b0, "reset pin in power-on");
		reset_in = 1'b0;
		settle(8'h80);
		chk(n >= 128 && n <= 140, "power-on hold length");
		for (int k = 0; k < 2; k++) begin
			b = bus_en;
			@(negedge mclk_in);
			chk(bus_en === ~b, "bus enable rate");
		end
		$display("test power-on done");
		for (int i = 0; i < 7; i++) begin
			hold_low = (i == 5);
			if (i == 0 || i == 5) exp_mode = (i == 5);
			hit(reset_sources_t'(7'h40 >> i), 8'h80 >> i);
		end
		$display("test sources done");
		for (int k = 0; k < 8; k++) begin
			seed = xorshift(seed);
			@(negedge mclk_in) tx_valid = 1'b1;
			tx_bit = seed[0];
			exp_q.push_back(seed[0]);
			@(negedge mclk_in) tx_valid = 1'b0;
			n = 1;
			hi = 1'b0;
			while (done !== 1'b1 && n < 40) begin
				if (pin_oe === 1'b1 && pin_o === 1'b1) hi = 1'b1;
				@(negedge mclk_in);
				n++;
			end
			chk(n >= 15 && n <= 19, "bit time");
			chk(hi === 1'b1, "speedup pulse");
			@(negedge mclk_in);
		end
		$display("test bits done");
		chk(exp_q.size() == 0, "bits left over");
		stop_test();
	end
	initial begin
		#400000;
		num_errors++;
		stop_test();
	end
endmodule : reset_and_debug_mode_select_bench
